/* rtl/iscp_port.sv */
// Local design decisions: the address map and the Wishbone interface to the registers.
`timescale 1ns/1ns
module iscp_port #(
  parameter int ADR_W = 8
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic rxd_i,
  output logic txd_o,
  output logic dtr_o,
  output logic rts_o
);
  iscp_pkg::iscp_ctrl_t ctrl_q, ctrl_d;
  iscp_pkg::iscp_rx_t rx_q, rx_d;
  logic ack_q, ack_d;
  logic [31:0] rdat_q, rdat_d;
  logic [9:0] div_cnt_q, div_cnt_d, div_val;
  logic tick_q, tick_d;
  logic [7:0] rec_mem [0:10];
  logic [3:0] fill_q, fill_d, rptr_q, rptr_d;
  logic rec_act_q, rec_act_d;
  logic mem_we;
  iscp_pkg::iscp_ser_st_t tx_st_q, tx_st_d, rx_st_q, rx_st_d;
  logic [3:0] tx_cnt_q, tx_cnt_d, rx_cnt_q, rx_cnt_d;
  logic [2:0] tx_bit_q, tx_bit_d, rx_bit_q, rx_bit_d;
  logic [7:0] tx_sh_q, tx_sh_d, rx_sh_q, rx_sh_d;
  logic txd_q, txd_d;
  logic req, wr, rd, cmd_ok, ser_on, tx_load, rx_done, rx_bad;
  logic [7:0] tx_byte;
  logic [ADR_W-1:0] adr8;

  assign req = wb_cyc_i && wb_stb_i && !ack_q;
  assign wr = req && wb_we_i && wb_sel_i[0];
  assign rd = req && !wb_we_i;
  assign adr8 = wb_adr_i;
  assign ser_on = ctrl_q.ifsel != iscp_pkg::IF_LAN;
  assign cmd_ok = ctrl_q.ifsel == iscp_pkg::IF_RS232 ||
                  ctrl_q.ifsel == iscp_pkg::IF_USB_COM;

  always_comb begin
    case (ctrl_q.baud)
      iscp_pkg::BR_A: div_val = iscp_pkg::DIV_A;
      iscp_pkg::BR_B: div_val = iscp_pkg::DIV_B;
      iscp_pkg::BR_C: div_val = iscp_pkg::DIV_C;
      default: div_val = iscp_pkg::DIV_D;
    endcase
    tick_d = div_cnt_q == 10'h000;
    div_cnt_d = tick_d ? div_val - 10'h001 : div_cnt_q - 10'h001;
  end

  // Register file and record buffer control.
  always_comb begin
    ctrl_d = ctrl_q;
    rx_d = rx_q;
    ack_d = wb_cyc_i && wb_stb_i && !ack_q;
    rdat_d = 32'h0000_0000;
    fill_d = fill_q;
    rptr_d = rptr_q;
    rec_act_d = rec_act_q;
    mem_we = 1'b0;
    tx_load = 1'b0;
    tx_byte = wb_dat_i[7:0];
    if (rd) begin
      case (adr8)
        iscp_pkg::ADR_CTRL: rdat_d[3:0] = ctrl_q;
        iscp_pkg::ADR_STATUS: begin
          rdat_d[iscp_pkg::ST_TX_BUSY] = tx_st_q != iscp_pkg::SER_IDLE;
          rdat_d[iscp_pkg::ST_RX_VALID] = rx_q.valid;
          rdat_d[iscp_pkg::ST_FRAME_ERR] = rx_q.frame_err;
          rdat_d[iscp_pkg::ST_OVERRUN] = rx_q.overrun;
          rdat_d[iscp_pkg::ST_REC_BUSY] = rec_act_q;
          rdat_d[iscp_pkg::ST_FILL_LSB +: 4] = fill_q;
        end
        iscp_pkg::ADR_RXDATA: begin
          rdat_d[7:0] = rx_q.data;
          rx_d.valid = 1'b0;
        end
        default: rdat_d = 32'h0000_0000;
      endcase
    end
    if (wr && adr8 == iscp_pkg::ADR_CTRL && !rec_act_q) begin
      ctrl_d = wb_dat_i[3:0];
      if (wb_dat_i[iscp_pkg::CTRL_REC_GO] && fill_q == iscp_pkg::REC_LEN &&
          ser_on) begin
        rec_act_d = 1'b1;
        rptr_d = 4'h0;
      end
    end
    if (wr && adr8 == iscp_pkg::ADR_STATUS) begin
      if (wb_dat_i[iscp_pkg::ST_FRAME_ERR]) rx_d.frame_err = 1'b0;
      if (wb_dat_i[iscp_pkg::ST_OVERRUN]) rx_d.overrun = 1'b0;
    end
    if (wr && adr8 == iscp_pkg::ADR_RECBUF && !rec_act_q &&
        fill_q != iscp_pkg::REC_LEN) begin
      mem_we = 1'b1;
      fill_d = fill_q + 4'h1;
    end
    if (rec_act_q && tx_st_q == iscp_pkg::SER_IDLE) begin
      if (rptr_q == iscp_pkg::REC_LEN) begin
        rec_act_d = 1'b0;
        fill_d = 4'h0;
      end else begin
        tx_load = 1'b1;
        tx_byte = rec_mem[rptr_q];
        rptr_d = rptr_q + 4'h1;
      end
    end else if (wr && adr8 == iscp_pkg::ADR_TXDATA && ser_on &&
                 !rec_act_q && tx_st_q == iscp_pkg::SER_IDLE) begin
      tx_load = 1'b1;
    end
    if (rx_done) begin
      if (rx_d.valid) rx_d.overrun = 1'b1;
      rx_d.valid = 1'b1;
      rx_d.data = rx_sh_q;
    end
    if (rx_bad) rx_d.frame_err = 1'b1;
  end

  always_comb begin
    tx_st_d = tx_st_q;
    tx_cnt_d = tx_cnt_q;
    tx_bit_d = tx_bit_q;
    tx_sh_d = tx_sh_q;
    case (tx_st_q)
      iscp_pkg::SER_IDLE: begin
        if (tx_load) begin
          tx_st_d = iscp_pkg::SER_START;
          tx_sh_d = tx_byte;
          tx_cnt_d = 4'h0;
          tx_bit_d = 3'h0;
        end
      end
      iscp_pkg::SER_START: begin
        if (tick_q) begin
          tx_cnt_d = tx_cnt_q + 4'h1;
          if (tx_cnt_q == iscp_pkg::OVS_LAST) tx_st_d = iscp_pkg::SER_DATA;
        end
      end
      iscp_pkg::SER_DATA: begin
        if (tick_q) begin
          tx_cnt_d = tx_cnt_q + 4'h1;
          if (tx_cnt_q == iscp_pkg::OVS_LAST) begin
            if (tx_bit_q == iscp_pkg::DATA_LAST) begin
              tx_st_d = iscp_pkg::SER_STOP;
            end else begin
              tx_sh_d = {1'b0, tx_sh_q[7:1]};
              tx_bit_d = tx_bit_q + 3'h1;
            end
          end
        end
      end
      iscp_pkg::SER_STOP: begin
        if (tick_q) begin
          tx_cnt_d = tx_cnt_q + 4'h1;
          if (tx_cnt_q == iscp_pkg::OVS_LAST) tx_st_d = iscp_pkg::SER_IDLE;
        end
      end
      default: tx_st_d = iscp_pkg::SER_IDLE;
    endcase
    // data leaves on the transmit line.
    case (tx_st_d)
      iscp_pkg::SER_START: txd_d = 1'b0;
      iscp_pkg::SER_DATA: txd_d = tx_sh_d[0];
      default: txd_d = 1'b1;
    endcase
  end

  always_comb begin
    rx_st_d = rx_st_q;
    rx_cnt_d = rx_cnt_q;
    rx_bit_d = rx_bit_q;
    rx_sh_d = rx_sh_q;
    rx_done = 1'b0;
    rx_bad = 1'b0;
    case (rx_st_q)
      iscp_pkg::SER_IDLE: begin
        if (!rxd_i && cmd_ok) begin
          rx_st_d = iscp_pkg::SER_START;
          rx_cnt_d = 4'h0;
        end
      end
      iscp_pkg::SER_START: begin
        if (tick_q) begin
          rx_cnt_d = rx_cnt_q + 4'h1;
          if (rx_cnt_q == iscp_pkg::OVS_MID) begin
            rx_st_d = rxd_i ? iscp_pkg::SER_IDLE : iscp_pkg::SER_DATA;
            rx_cnt_d = 4'h0;
            rx_bit_d = 3'h0;
          end
        end
      end
      iscp_pkg::SER_DATA: begin
        if (tick_q) begin
          rx_cnt_d = rx_cnt_q + 4'h1;
          if (rx_cnt_q == iscp_pkg::OVS_LAST) begin
            rx_sh_d = {rxd_i, rx_sh_q[7:1]};
            rx_bit_d = rx_bit_q + 3'h1;
            if (rx_bit_q == iscp_pkg::DATA_LAST) rx_st_d = iscp_pkg::SER_STOP;
          end
        end
      end
      iscp_pkg::SER_STOP: begin
        if (tick_q) begin
          rx_cnt_d = rx_cnt_q + 4'h1;
          if (rx_cnt_q == iscp_pkg::OVS_LAST) begin
            rx_st_d = iscp_pkg::SER_IDLE;
            rx_done = rxd_i && cmd_ok;
            rx_bad = !rxd_i;
          end
        end
      end
      default: rx_st_d = iscp_pkg::SER_IDLE;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_q <= iscp_pkg::CTRL_RST;
      rx_q <= '0;
      ack_q <= 1'b0;
      rdat_q <= 32'h0000_0000;
      div_cnt_q <= 10'h000;
      tick_q <= 1'b0;
      fill_q <= 4'h0;
      rptr_q <= 4'h0;
      rec_act_q <= 1'b0;
      tx_st_q <= iscp_pkg::SER_IDLE;
      tx_cnt_q <= 4'h0;
      tx_bit_q <= 3'h0;
      tx_sh_q <= 8'h00;
      txd_q <= 1'b1;
      rx_st_q <= iscp_pkg::SER_IDLE;
      rx_cnt_q <= 4'h0;
      rx_bit_q <= 3'h0;
      rx_sh_q <= 8'h00;
    end else begin
      ctrl_q <= ctrl_d;
      rx_q <= rx_d;
      ack_q <= ack_d;
      rdat_q <= rdat_d;
      div_cnt_q <= div_cnt_d;
      tick_q <= tick_d;
      fill_q <= fill_d;
      rptr_q <= rptr_d;
      rec_act_q <= rec_act_d;
      tx_st_q <= tx_st_d;
      tx_cnt_q <= tx_cnt_d;
      tx_bit_q <= tx_bit_d;
      tx_sh_q <= tx_sh_d;
      txd_q <= txd_d;
      rx_st_q <= rx_st_d;
      rx_cnt_q <= rx_cnt_d;
      rx_bit_q <= rx_bit_d;
      rx_sh_q <= rx_sh_d;
    end
  end

  always_ff @(posedge clk_i) begin
    if (mem_we) rec_mem[fill_q] <= wb_dat_i[7:0];
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdat_q;
  // only receive and transmit data used.
  assign txd_o = txd_q;
  assign dtr_o = 1'b1;
  assign rts_o = 1'b1;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_rx_stop_low;
    rx_st_q == iscp_pkg::SER_STOP && tick_q &&
      rx_cnt_q == iscp_pkg::OVS_LAST && !rxd_i;
  endsequence

  chk_modem_on: assert property (dtr_o && rts_o)
    else $error("modem outputs not asserted");
  chk_one_iface: assert property ($rose(rx_q.valid) |-> $past(cmd_ok))
    else $error("character taken on unselected interface");
  chk_kbd_no_cmd: assert property (
    ctrl_q.ifsel == iscp_pkg::IF_USB_KBD && $stable(ctrl_q) |=>
      rx_st_q == iscp_pkg::SER_IDLE || $past(rx_st_q) != iscp_pkg::SER_IDLE)
    else $error("receiver started in keyboard mode");
  chk_lan_quiet: assert property (
    ctrl_q.ifsel == iscp_pkg::IF_LAN && tx_st_q == iscp_pkg::SER_IDLE |=>
      txd_o || $past(rec_act_q))
    else $error("serial line driven in network mode");
  chk_start_low: assert property (
    tx_st_q == iscp_pkg::SER_START |-> !txd_o)
    else $error("start bit not low");
  chk_stop_high: assert property (
    tx_st_q == iscp_pkg::SER_DATA ##1 tx_st_q == iscp_pkg::SER_STOP |->
      txd_o && $past(tx_bit_q) == 3'h7)
    else $error("stop bit wrong or data count off");
  chk_fast_rate: assert property (
    tick_q && ctrl_q.baud == iscp_pkg::BR_D && $stable(ctrl_q.baud) |=>
      !tick_q [*8])
    else $error("oversample tick too frequent");
  chk_record_len: assert property (
    $fell(rec_act_q) |-> $past(rptr_q) == 4'hB && fill_q == 4'h0)
    else $error("record not eleven characters");
  chk_frame_flag: assert property (s_rx_stop_low |=> rx_q.frame_err)
    else $error("framing error not flagged");
  chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
endmodule

/* rtl/iscp_pkg.sv */
package iscp_pkg;
  localparam int unsigned CLK_HZ = 100_000_000;
  localparam int unsigned OVS = 16;
  localparam int unsigned BAUD_A = 9600;
  localparam int unsigned BAUD_B = 19200;
  localparam int unsigned BAUD_C = 38400;
  localparam int unsigned BAUD_D = 115200;
  localparam logic [9:0] DIV_A = 10'(CLK_HZ / (BAUD_A * OVS));
  localparam logic [9:0] DIV_B = 10'(CLK_HZ / (BAUD_B * OVS));
  localparam logic [9:0] DIV_C = 10'(CLK_HZ / (BAUD_C * OVS));
  localparam logic [9:0] DIV_D = 10'(CLK_HZ / (BAUD_D * OVS));
  localparam logic [3:0] OVS_LAST = 4'hF;
  localparam logic [3:0] OVS_MID = 4'h7;
  localparam logic [2:0] DATA_LAST = 3'h7;
  localparam logic [3:0] REC_LEN = 4'hB;
  localparam logic [7:0] ADR_CTRL = 8'h00;
  localparam logic [7:0] ADR_STATUS = 8'h04;
  localparam logic [7:0] ADR_TXDATA = 8'h08;
  localparam logic [7:0] ADR_RXDATA = 8'h0C;
  localparam logic [7:0] ADR_RECBUF = 8'h10;
  localparam int CTRL_IF_LSB = 0;
  localparam int CTRL_BAUD_LSB = 2;
  localparam int CTRL_REC_GO = 4;
  localparam int ST_TX_BUSY = 0;
  localparam int ST_RX_VALID = 1;
  localparam int ST_FRAME_ERR = 2;
  localparam int ST_OVERRUN = 3;
  localparam int ST_REC_BUSY = 4;
  localparam int ST_FILL_LSB = 8;
  localparam logic [3:0] CTRL_RST = 4'h0;
  typedef enum logic [1:0] {
    IF_RS232 = 2'h0,
    IF_USB_COM = 2'h1,
    IF_USB_KBD = 2'h2,
    IF_LAN = 2'h3
  } iscp_if_t;
  typedef enum logic [1:0] {
    BR_A = 2'h0,
    BR_B = 2'h1,
    BR_C = 2'h2,
    BR_D = 2'h3
  } iscp_baud_t;
  typedef struct packed {
    iscp_baud_t baud;
    iscp_if_t ifsel;
  } iscp_ctrl_t;
  typedef struct packed {
    logic overrun;
    logic frame_err;
    logic valid;
    logic [7:0] data;
  } iscp_rx_t;
  typedef enum logic [1:0] {
    SER_IDLE = 2'h0,
    SER_START = 2'h1,
    SER_DATA = 2'h3,
    SER_STOP = 2'h2
  } iscp_ser_st_t;
endpackage

/* bench/iscp_ctl_model.sv */
`timescale 1ns/1ns
module iscp_ctl_model #(
  parameter int BT = 864
) (
  input wire logic clk_i,
  input wire logic rxd_i,
  output logic txd_o
);
  logic [7:0] rx_q [$];
  int stop_bad = 0;
  logic [7:0] d;
  initial txd_o = 1'b1;
  // 8-bit commands at matched rate, stop bit level set by stp.
  task automatic send(input logic [7:0] b, input logic stp);
    logic [9:0] f;
    f = {stp, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(posedge clk_i);
      txd_o <= f[i];
      repeat (BT - 1) @(posedge clk_i);
    end
    @(posedge clk_i);
    txd_o <= 1'b1;
  endtask
  // device TxD is sampled at bit centres.
  initial begin
    forever begin
      @(negedge rxd_i);
      repeat (BT / 2) @(posedge clk_i);
      for (int i = 0; i < 8; i++) begin
        repeat (BT) @(posedge clk_i);
        d[i] = rxd_i;
      end
      repeat (BT) @(posedge clk_i);
      if (rxd_i !== 1'b1) stop_bad++;
      rx_q.push_back(d);
    end
  end
endmodule

/* bench/iscp_port_tb.sv */
`timescale 1ns/1ns
module iscp_port_tb;
  localparam int BT = 16 * 54;
  typedef struct packed {
    logic we;
    logic [7:0] adr;
    logic [31:0] dat;
    logic [31:0] exp;
  } iscp_row_t;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0;
  logic [31:0] wb_dat_o;
  logic wb_ack_o, txd_o, dtr_o, rts_o, rxd_i;
  int err_count = 0;
  int checks = 0;
  int n;
  logic [31:0] rd;
  iscp_row_t rows [9] = '{
    '{1'b0, 8'h00, 32'h0, 32'h0},
    '{1'b1, 8'h00, 32'hF, 32'h0},
    '{1'b0, 8'h00, 32'h0, 32'hF},
    '{1'b1, 8'h08, 32'h55, 32'h0},
    '{1'b0, 8'h04, 32'h0, 32'h0},
    '{1'b1, 8'h20, 32'hFF, 32'h0},
    '{1'b0, 8'h20, 32'h0, 32'h0},
    '{1'b1, 8'h00, 32'h1D, 32'h0},
    '{1'b0, 8'h00, 32'h0, 32'hD}};

  always #5 clk_i = ~clk_i;

  iscp_port dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .rxd_i(rxd_i), .txd_o(txd_o), .dtr_o(dtr_o),
    .rts_o(rts_o));
  iscp_ctl_model #(.BT(BT)) mdl (.clk_i(clk_i), .rxd_i(txd_o),
    .txd_o(rxd_i));

  task automatic chk(input string nm, input logic [31:0] seen, exp);
    checks++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic bus(input logic we, input logic [7:0] adr,
    input logic [31:0] dat);
    int k;
    k = 0;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_sel_i <= 4'h1;
    wb_dat_i <= dat;
    do begin
      @(posedge clk_i);
      k++;
    end while (wb_ack_o !== 1'b1 && k < 50);
    rd = wb_dat_o;
    if (k >= 50) chk("wb_ack_o", 32'h0, 32'h1);
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
  endtask

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  initial begin
    repeat (105000) @(posedge clk_i);
    err_count++;
    print_verdict();
  end

  initial begin
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    chk("dtr_rts", {30'h0, dtr_o, rts_o}, 32'h3);
    foreach (rows[i]) begin
      bus(rows[i].we, rows[i].adr, rows[i].dat);
      if (!rows[i].we) chk("row", rd, rows[i].exp);
    end
    for (int b = 0; b < 4; b++) begin
      bus(1'b1, 8'h00, 32'(b * 4 + 1));
      bus(1'b0, 8'h00, 32'h0);
      chk("ctrl", rd, 32'(b * 4 + 1));
    end
    $display("test registers done");
    for (int i = 0; i < 12; i++) bus(1'b1, 8'h10, 32'(8'h41 + i));
    bus(1'b0, 8'h04, 32'h0);
    chk("fill", rd & 32'hF10, 32'hB00);
    bus(1'b1, 8'h00, 32'hE);
    fork
      begin
        mdl.send(8'hFF, 1'b1);
        bus(1'b0, 8'h04, 32'h0);
        chk("kbd_quiet", rd & 32'h2, 32'h0);
        mdl.send(8'h3C, 1'b0);
        repeat (20) @(posedge clk_i);
        bus(1'b0, 8'h04, 32'h0);
        chk("frame_err", rd & 32'h4, 32'h4);
        bus(1'b1, 8'h04, 32'h4);
        bus(1'b0, 8'h04, 32'h0);
        chk("frame_clr", rd & 32'h4, 32'h0);
        repeat (10 * BT) @(posedge clk_i);
        bus(1'b0, 8'h0C, 32'h0);
        mdl.send(8'hA5, 1'b1);
      end
      begin
        repeat (BT + BT / 2) @(posedge clk_i);
        bus(1'b1, 8'h00, 32'h1D);
        bus(1'b0, 8'h04, 32'h0);
        chk("rec_busy", rd & 32'h10, 32'h10);
        n = 0;
        while (mdl.rx_q.size() < 11 && n < 100000) begin
          @(posedge clk_i);
          n++;
        end
      end
    join
    for (int i = 0; i < 11; i++) chk("rec", mdl.rx_q[i], 8'h41 + i);
    chk("stop", mdl.stop_bad, 32'h0);
    repeat (BT) @(posedge clk_i);
    bus(1'b0, 8'h04, 32'h0);
    chk("status", rd & 32'hF1F, 32'h2);
    bus(1'b0, 8'h0C, 32'h0);
    chk("rxdata", rd & 32'hFF, 32'hA5);
    chk("rec_total", mdl.rx_q.size(), 32'hB);
    $display("test record, duplex and framing done");
    bus(1'b1, 8'h00, 32'hF);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    chk("dtr_rts_rst", {30'h0, dtr_o, rts_o}, 32'h3);
    rst_i <= 1'b0;
    bus(1'b0, 8'h00, 32'h0);
    chk("ctrl_rst", rd, 32'h0);
    bus(1'b0, 8'h04, 32'h0);
    chk("status_rst", rd, 32'h0);
    chk("dtr_rts", {30'h0, dtr_o, rts_o}, 32'h3);
    $display("test reset done");
    print_verdict();
  end
endmodule
